// >>> cuf_ctrl_model.sv
// Purpose: Controller model holding the curve transfer block
// Assumes: Word requests arrive on sys_clk
// Notes:   Answers at a random pace; idle data is scrambled
`default_nettype none
module cuf_ctrl_model (
  input  wire logic        sys_clk,
  input  wire logic        fetch_req,
  input  wire logic [7:0]  fetch_addr,
  output logic             fetch_ack,
  output logic [15:0]      fetch_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] blk [0:255]; // Full 256-word block of 16-bit words
  logic [7:0]  max_addr;    // Highest word handed out, cleared by the bench
  int          seed;        // Own pacing sequence
  initial
  begin
    fetch_ack = 1'b0;
    fetch_data = 16'h0000;
    max_addr = 8'h00;
    seed = 8;
  end
  // One word per pulse; stale data inverted so it never passes for valid
  always @(posedge sys_clk)
  begin
    if (fetch_ack && fetch_req)
    begin
      fetch_ack <= 1'b0;
      fetch_data <= ~fetch_data;
    end
    else if (fetch_req && ($random(seed) & 3) != 0)
    begin
      fetch_ack <= 1'b1;
      fetch_data <= blk[fetch_addr];
      if (fetch_addr > max_addr)
        max_addr <= fetch_addr;
    end
  end
endmodule
`default_nettype wire

// >>> cuf_curve_update_fetch.v
// Purpose: Fetches the curve transfer block and plots curve values
// Assumes: Word port on sys_clk; comm flag pin is asynchronous
// Notes:   One plot point is held at a time; fetching stalls on it
// Functional notes
// - No-old mode fetches words 0 to 6
// - High check byte: presence bits 8 to 13
// - Curve n value comes from word n+1
// - Absent curves' value words are ignored
// - Plot only curves defined in configuration
// - Old mode reads whole block once, plots olds
// - Cyclic updating starts after olds plotted
// - Old-mode cyclic updates fetch words 0 to 9
// - Controller trigger fetches block, plots olds
// - Flag rising edge starts an update
// - Controller mode: word 7 low byte spacing
// - One time step equals 80 pixels
// - Controller mode ignores configured time unit
// - Block read at configured update interval
// - Old mode checks counter word against previous
// - Faster controller: interpolate, raise warning
// - Slower controller: follow its pace
// - No-old mode: missed interval interpolates, warns
// - Current values are 16-bit words 1-6
// - Olds start at word 10; block max 256
`include "cuf_defines.vh"
`default_nettype none

module cuf_curve_update_fetch #(
  parameter [31:0] UPD_CYC = `CUF_UPD_TIME_MS * `CUF_CLK_KHZ
)(
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire        fetch_req,
  output reg  [7:0]  fetch_addr,
  input  wire        fetch_ack,
  input  wire [15:0] fetch_data,
  input  wire        comm_flag_pin,
  output reg         plot_valid,
  input  wire        plot_ready,
  output reg  [2:0]  plot_curve,
  output reg  [15:0] plot_value,
  output reg         plot_old,
  output reg         plot_interp,
  output reg  [15:0] plot_x,
  output reg  [7:0]  plot_step,
  output wire        interp_warn
);

  // One-hot fetch states
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_REQ  = 4'b0010;
  localparam [3:0] S_FIN  = 4'b0100;
  localparam [3:0] S_EMIT = 4'b1000;

  // Curve present in the check word and defined in the window
  function curve_on;
    input [15:0] chk;
    input [5:0]  def;
    input [2:0]  n;
    begin
      curve_on = chk[`CUF_PRES_LSB + n] & def[n];
    end
  endfunction

  // Software-visible configuration
  reg        en_reg;       // Block enable
  reg [1:0]  mode_reg;     // Update mode
  reg [5:0]  def_reg;      // Curves defined in the window
  reg [7:0]  cfg_sp_reg;   // Spacing for timer-driven modes
  reg [1:0]  tunit_reg;    // Time unit, stored only
  reg [31:0] upd_reg;      // Update interval in cycles
  reg        warn_reg;     // Sticky interpolation warning

  // Fetch engine state
  reg [3:0]  state_reg;
  reg [7:0]  last_reg;     // Last word of this pass
  reg        full_reg;     // Pass reads the whole block
  reg        end_reg;      // Last word has been taken
  reg        built_reg;    // Old values already plotted
  reg [15:0] chk_reg;      // Check word
  reg [7:0]  sp_reg;       // Spacing from the block
  reg [15:0] cnt_reg;      // Counter of previous update
  reg [15:0] cnt_new_reg;  // Counter of this update
  reg [7:0]  opos_reg;     // Old value position in curve
  reg [2:0]  ocur_reg;     // Curve of the old value area
  reg [2:0]  idx_reg;      // Curve being emitted
  reg        iph_reg;      // Interpolated point done
  reg        interp_reg;   // This update interpolates
  reg        miss_reg;     // Interval missed while busy
  reg [5:0]  pval_reg;     // Previous value exists
  reg [31:0] tmr_reg;      // Update interval timer
  reg        flag_s1_reg;  // Flag synchroniser, stage 1
  reg        flag_s2_reg;  // Flag synchroniser, stage 2
  reg        flag_s3_reg;  // Delayed copy for edge detect
  reg [15:0] cur_mem [0:5];  // Latest current values
  reg [15:0] prev_mem [0:5]; // Values plotted last time
  reg [31:0] rd_next;

  // APB decode; zero wait states
  wire apb_acc = psel & penable;
  wire hit_ctrl = (paddr == `CUF_CTRL_OFS);
  wire hit_cfg  = (paddr == `CUF_CFG_OFS);
  wire hit_upd  = (paddr == `CUF_UPD_OFS);
  wire hit_stat = (paddr == `CUF_STAT_OFS);
  wire hit_cnt  = (paddr == `CUF_CNT_OFS);
  wire mapped = hit_ctrl | hit_cfg | hit_upd | hit_stat | hit_cnt;
  wire apb_wr = apb_acc & pwrite & mapped;
  wire ctrl_wr = apb_wr & hit_ctrl;
  assign pready = 1'b1;
  assign pslverr = apb_acc & ~mapped;

  // Derived signals
  wire slot = ~plot_valid | plot_ready;
  wire flag_rise = flag_s2_reg & ~flag_s3_reg;
  wire tick = (tmr_reg + 32'h0000_0001) >= upd_reg;
  wire busy = ~state_reg[0];
  wire ctrl_mode = (mode_reg == `CUF_MODE_CTRL);
  wire old_mode = (mode_reg == `CUF_MODE_OLD);
  // Controller mode takes spacing from the block, time unit unused
  wire [7:0] sp_use = ctrl_mode ? sp_reg : cfg_sp_reg;
  wire [15:0] ox = {8'h00, opos_reg} * {8'h00, sp_use};
  wire [15:0] ostep = ox / `CUF_PIX_PER_STEP;
  wire in_old = (ocur_reg < `CUF_NCURVES) & (opos_reg < chk_reg[7:0]);
  wire [15:0] cdelta = cnt_new_reg - cnt_reg;
  wire [15:0] cv = cur_mem[idx_reg];
  wire [15:0] pvv = prev_mem[idx_reg];
  wire [16:0] isum = {cv[15], cv} + {pvv[15], pvv};
  wire fin_warn = state_reg[2] & ~full_reg &
    ((old_mode & (cdelta > 16'h0001)) | (~old_mode & miss_reg));
  assign interp_warn = warn_reg;
  assign fetch_req = state_reg[1] & ~end_reg & ~plot_valid;

  // Comm flag synchroniser
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      flag_s1_reg <= 1'b0;
      flag_s2_reg <= 1'b0;
      flag_s3_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      flag_s1_reg <= comm_flag_pin;
      flag_s2_reg <= flag_s1_reg;
      flag_s3_reg <= flag_s2_reg;
    end
  end

  // Read data mux
  always @*
  begin
    if (hit_ctrl)
      rd_next = {29'h0000_0000, mode_reg, en_reg};
    else if (hit_cfg)
      rd_next = {14'h0000, tunit_reg, cfg_sp_reg, 2'b00, def_reg};
    else if (hit_upd)
      rd_next = upd_reg;
    else if (hit_stat)
      rd_next = {10'h000, chk_reg[13:8], chk_reg[7:0], state_reg,
                 1'b0, warn_reg, built_reg, busy};
    else if (hit_cnt)
      rd_next = {8'h00, sp_reg, cnt_reg};
    else
      rd_next = 32'h0000_0000;
  end

  // Register file; read data latched in the setup cycle
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      en_reg     <= 1'b0;
      mode_reg   <= `CUF_MODE_NOOLD;
      def_reg    <= `CUF_DEF_RST;
      cfg_sp_reg <= `CUF_SP_RST;
      tunit_reg  <= 2'b00;
      upd_reg    <= UPD_CYC;
      warn_reg   <= 1'b0;
      prdata     <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      if (psel & ~penable)
        prdata <= rd_next;
      if (ctrl_wr)
      begin
        en_reg   <= pwdata[`CUF_CTRL_EN_BIT];
        mode_reg <= pwdata[`CUF_CTRL_MODE_LSB +: 2];
      end
      if (apb_wr & hit_cfg)
      begin
        def_reg    <= pwdata[5:0];
        cfg_sp_reg <= pwdata[`CUF_CFG_SP_LSB +: 8];
        tunit_reg  <= pwdata[`CUF_CFG_TU_LSB +: 2];
      end
      if (apb_wr & hit_upd)
        upd_reg <= pwdata;
      // Write one clears; a new warning in the same cycle wins
      warn_reg <= (warn_reg & ~(apb_wr & hit_stat & pwdata[`CUF_STAT_WARN_BIT]))
                  | fin_warn;
    end
  end

  // Update timer, runs only in timer-driven modes
  always @(posedge sys_clk)
  begin
    if (srst)
      tmr_reg <= 32'h0000_0000;
    else if (clk_en)
    begin
      if (~en_reg | ctrl_mode | tick)
        tmr_reg <= 32'h0000_0000;
      else
        tmr_reg <= tmr_reg + 32'h0000_0001;
    end
  end

  // Fetch, timing check and plot engine
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_reg   <= S_IDLE;
      last_reg    <= `CUF_W_LAST_NOOLD;
      full_reg    <= 1'b0;
      end_reg     <= 1'b0;
      built_reg   <= 1'b0;
      chk_reg     <= 16'h0000;
      sp_reg      <= 8'h00;
      cnt_reg     <= 16'h0000;
      cnt_new_reg <= 16'h0000;
      opos_reg    <= 8'h00;
      ocur_reg    <= 3'h0;
      idx_reg     <= 3'h0;
      iph_reg     <= 1'b0;
      interp_reg  <= 1'b0;
      miss_reg    <= 1'b0;
      pval_reg    <= 6'h00;
      fetch_addr  <= 8'h00;
      plot_valid  <= 1'b0;
      plot_curve  <= 3'h0;
      plot_value  <= 16'h0000;
      plot_old    <= 1'b0;
      plot_interp <= 1'b0;
      plot_x      <= 16'h0000;
      plot_step   <= 8'h00;
    end
    else if (clk_en)
    begin
      // Plot slot empties when taken
      if (plot_valid & plot_ready)
        plot_valid <= 1'b0;
      // Rebuild the display after any control write
      if (ctrl_wr)
        built_reg <= 1'b0;
      // Interval elapsed while a fetch is still running
      if (tick & busy & ~ctrl_mode)
        miss_reg <= 1'b0 | ~old_mode;
      case (state_reg)
        S_IDLE:
        begin
          end_reg    <= 1'b0;
          fetch_addr <= `CUF_W_CHECK;
          opos_reg   <= 8'h00;
          ocur_reg   <= 3'h0;
          if (en_reg & ctrl_mode & flag_rise)
          begin
            // Controller-initiated pass over the whole block
            full_reg  <= 1'b1;
            last_reg  <= `CUF_W_LAST_BLOCK;
            state_reg <= S_REQ;
          end
          else if (en_reg & old_mode & ~built_reg & ~ctrl_wr)
          begin
            full_reg  <= 1'b1;
            last_reg  <= `CUF_W_LAST_BLOCK;
            state_reg <= S_REQ;
          end
          else if (en_reg & tick & ~ctrl_mode & (~old_mode | built_reg))
          begin
            full_reg  <= 1'b0;
            last_reg  <= old_mode ? `CUF_W_LAST_CYC : `CUF_W_LAST_NOOLD;
            state_reg <= S_REQ;
          end
        end
        S_REQ:
        begin
          if (end_reg & ~plot_valid)
            state_reg <= S_FIN;
          else if (fetch_ack & fetch_req)
          begin
            fetch_addr <= fetch_addr + 8'h01;
            end_reg    <= (fetch_addr == last_reg);
            if (fetch_addr == `CUF_W_CHECK)
              chk_reg <= fetch_data;
            else if (fetch_addr <= `CUF_W_LAST_NOOLD)
            begin
              // Only present and defined curves keep their value
              if (curve_on(chk_reg, def_reg, fetch_addr[2:0] - 3'h1))
                cur_mem[fetch_addr[2:0] - 3'h1] <= fetch_data;
            end
            else if (fetch_addr == `CUF_W_SPACING)
            begin
              if (ctrl_mode)
                sp_reg <= fetch_data[7:0];
            end
            else if (fetch_addr == `CUF_W_COUNTER)
              cnt_new_reg <= fetch_data;
            else if ((fetch_addr >= `CUF_W_OLD_BASE) & full_reg & in_old)
            begin
              // Old values are laid out curve after curve
              if (curve_on(chk_reg, def_reg, ocur_reg))
              begin
                plot_valid  <= 1'b1;
                plot_curve  <= ocur_reg;
                plot_value  <= fetch_data;
                plot_old    <= 1'b1;
                plot_interp <= 1'b0;
                plot_x      <= ox;
                plot_step   <= ostep[7:0];
              end
              if ((opos_reg + 8'h01) == chk_reg[7:0])
              begin
                opos_reg <= 8'h00;
                ocur_reg <= ocur_reg + 3'h1;
              end
              else
                opos_reg <= opos_reg + 8'h01;
            end
          end
        end
        S_FIN:
        begin
          idx_reg <= 3'h0;
          iph_reg <= 1'b0;
          if (full_reg)
          begin
            // Baseline counter for later cyclic checks
            cnt_reg   <= cnt_new_reg;
            built_reg <= built_reg | (old_mode & ~ctrl_wr);
            state_reg <= S_IDLE;
          end
          else if (old_mode)
          begin
            cnt_reg <= cnt_new_reg;
            if (cdelta == 16'h0000)
              state_reg <= S_IDLE;
            else
            begin
              interp_reg <= (cdelta > 16'h0001);
              state_reg  <= S_EMIT;
            end
          end
          else
          begin
            interp_reg <= miss_reg;
            miss_reg   <= 1'b0;
            state_reg  <= S_EMIT;
          end
        end
        S_EMIT:
        begin
          if (slot)
          begin
            if (curve_on(chk_reg, def_reg, idx_reg) & interp_reg
                & pval_reg[idx_reg] & ~iph_reg)
            begin
              // Midpoint stands in for the value that was missed
              plot_valid  <= 1'b1;
              plot_curve  <= idx_reg;
              plot_value  <= isum[16:1];
              plot_old    <= 1'b0;
              plot_interp <= 1'b1;
              plot_x      <= 16'h0000;
              plot_step   <= 8'h00;
              iph_reg     <= 1'b1;
            end
            else
            begin
              if (curve_on(chk_reg, def_reg, idx_reg))
              begin
                plot_valid  <= 1'b1;
                plot_curve  <= idx_reg;
                plot_value  <= cv;
                plot_old    <= 1'b0;
                plot_interp <= 1'b0;
                plot_x      <= 16'h0000;
                plot_step   <= 8'h00;
                prev_mem[idx_reg] <= cv;
                pval_reg[idx_reg] <= 1'b1;
              end
              iph_reg <= 1'b0;
              if (idx_reg == `CUF_LAST_CURVE)
                state_reg <= S_IDLE;
              else
                idx_reg <= idx_reg + 3'h1;
            end
          end
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> cuf_curve_update_fetch_properties.sv
// Purpose: Port checks of the curve update fetch block
// Assumes: One clock, srst synchronous active high
// Notes:   Sees only the top-level ports
`default_nettype none
module cuf_check_props (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pslverr,
  input wire logic        fetch_req,
  input wire logic [7:0]  fetch_addr,
  input wire logic        fetch_ack,
  input wire logic        plot_valid,
  input wire logic        plot_ready,
  input wire logic [2:0]  plot_curve,
  input wire logic [15:0] plot_value,
  input wire logic        plot_interp,
  input wire logic [15:0] plot_x,
  input wire logic [7:0]  plot_step,
  input wire logic        interp_warn
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // A word taken from the controller
  sequence s_take;
    fetch_req && fetch_ack && clk_en;
  endsequence
  // A point offered but refused this cycle
  sequence s_stall;
    plot_valid && !plot_ready && clk_en;
  endsequence
  addr_step_a: assert property (s_take ##1 fetch_req |-> fetch_addr == $past(fetch_addr) + 8'h01)
    else $error("word index did not advance");
  addr_hold_a: assert property (fetch_req && !fetch_ack && clk_en |=> fetch_addr == $past(fetch_addr))
    else $error("word index moved without answer");
  plot_hold_a: assert property (s_stall |=> plot_valid && $stable(plot_value) && $stable(plot_curve))
    else $error("plot point dropped or changed");
  step_scale_a: assert property (plot_valid |-> plot_step == 8'(plot_x / 16'h0050))
    else $error("step does not match pixel offset");
  curve_range_a: assert property (plot_valid |-> plot_curve <= 3'h5)
    else $error("curve number out of range");
  interp_warn_a: assert property (plot_valid && plot_interp |-> interp_warn)
    else $error("interpolated point without warning");
  fetch_stop_a: assert property (s_stall |-> !fetch_req)
    else $error("fetching while a point is pending");
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
endmodule
`default_nettype wire

// >>> cuf_defines.vh
// Purpose: Shared constants of the curve update fetch block
// Assumes: Included by cuf_curve_update_fetch.v only
// Notes:   Register offsets are APB byte addresses
`ifndef CUF_DEFINES_VH
`define CUF_DEFINES_VH

// Register byte offsets
`define CUF_CTRL_OFS      12'h000
`define CUF_CFG_OFS       12'h004
`define CUF_UPD_OFS       12'h008
`define CUF_STAT_OFS      12'h00c
`define CUF_CNT_OFS       12'h010

// Field positions
`define CUF_CTRL_EN_BIT   0
`define CUF_CTRL_MODE_LSB 1
`define CUF_CFG_SP_LSB    8
`define CUF_CFG_TU_LSB    16
`define CUF_STAT_WARN_BIT 2

// Update mode codes
`define CUF_MODE_NOOLD    2'h0
`define CUF_MODE_OLD      2'h1
`define CUF_MODE_CTRL     2'h2

// Reset values
`define CUF_DEF_RST       6'h3f
`define CUF_SP_RST        8'h01

// Transfer block word indices, presence bit, curve and pixel constants
`define CUF_W_CHECK       8'h00
`define CUF_W_LAST_NOOLD  8'h06
`define CUF_W_SPACING     8'h07
`define CUF_W_COUNTER     8'h08
`define CUF_W_LAST_CYC    8'h09
`define CUF_W_OLD_BASE    8'h0a
`define CUF_W_LAST_BLOCK  8'hff
`define CUF_PRES_LSB      8
`define CUF_LAST_CURVE    3'h5
`define CUF_NCURVES       3'h6
`define CUF_PIX_PER_STEP  16'h0050

// Timing: update time in ms and clock rate in kHz
`define CUF_UPD_TIME_MS   1000
`define CUF_CLK_KHZ       40000

`endif

// >>> tb.sv
// Purpose: Self-checking bench of the curve update fetch block
// Assumes: 40 MHz clock, update interval shortened to 200 cycles
// Notes:   Consumer stalls at random; controller model paces words
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int UPD = 200;
  logic        sys_clk = 0;
  logic        srst = 1;
  logic        clk_en = 1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic        comm_flag_pin = 0;
  logic        plot_ready = 0;
  logic        stall = 0;    // Holds the consumer back
  wire  [31:0] prdata;
  wire         pready, pslverr, fetch_req, fetch_ack, plot_valid, plot_old, plot_interp, interp_warn;
  wire  [7:0]  fetch_addr, plot_step;
  wire  [15:0] fetch_data, plot_value, plot_x;
  wire  [2:0]  plot_curve;
  int          miscompares = 0, samples_checked = 0, seed = 8, cyc = 0, i, c, p;
  logic [36:0] qo[$], qc[$], e[$]; // Old points, current points, expected
  logic [31:0] r;
  logic        slv;
  logic [5:0]  def;
  logic [7:0]  sp;
  cuf_curve_update_fetch #(.UPD_CYC(UPD)) DUT (.sys_clk, .srst, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .fetch_req, .fetch_addr, .fetch_ack, .fetch_data, .comm_flag_pin,
    .plot_valid, .plot_ready, .plot_curve, .plot_value, .plot_old, .plot_interp, .plot_x, .plot_step, .interp_warn);
  cuf_ctrl_model ctrl (.sys_clk, .fetch_req, .fetch_addr, .fetch_ack, .fetch_data);
  always #12.5 sys_clk = ~sys_clk;
  // Random consumer; accepted points are filed by kind
  always @(posedge sys_clk)
  begin
    plot_ready <= !stall && ($random(seed) & 3) != 0;
    cyc <= cyc + 1;
    if (plot_valid && plot_ready && plot_old)
      qo.push_back({plot_interp, plot_old, plot_curve, plot_value, plot_x});
    else if (plot_valid && plot_ready)
      qc.push_back({plot_interp, plot_old, plot_curve, plot_value, plot_x});
    if (cyc == 40000)
    begin
      miscompares++;
      results();
    end
  end
  task automatic chk(input logic [36:0] got, input logic [36:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // APB transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic setblk(input logic [7:0] n);
    for (i = 0; i < 256; i++)
      ctrl.blk[i] = 16'($random(seed));
    ctrl.blk[0] = {2'b00, 6'($random(seed)) | 6'h01, n};
  endtask
  // Present and defined curves, values from words 1 to 6
  task automatic exp_cur();
    e = {};
    for (c = 0; c < 6; c++)
      if (ctrl.blk[0][8+c] && def[c])
        e.push_back({2'b00, c[2:0], ctrl.blk[c+1], 16'h0000});
  endtask
  // Old values curve by curve, newest first
  task automatic exp_old(input logic [7:0] s);
    e = {};
    for (c = 0; c < 6; c++)
      if (ctrl.blk[0][8+c] && def[c])
        for (p = 0; p < ctrl.blk[0][7:0]; p++)
          e.push_back({2'b01, c[2:0], ctrl.blk[10+c*ctrl.blk[0][7:0]+p], 16'(p * s)});
  endtask
  task automatic cmp(ref logic [36:0] q[$]);
    for (i = 0; i < 4000 && q.size() < e.size(); i++)
      @(posedge sys_clk);
    chk(q.size() >= e.size(), 1);
    for (i = 0; i < e.size() && i < q.size(); i++)
      chk(q[i], e[i]);
    q = {};
  endtask
  task automatic wait_end();
    for (i = 0; i < 3000 && ctrl.max_addr != 8'hff; i++)
      @(posedge sys_clk);
    chk(ctrl.max_addr, 8'hff);
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    srst <= 0;
    for (int k = 0; k < 6; k++)
    begin
      apb(1'b0, 12'(k * 4), 32'h0000_0000);
      // Idle state reads back as its one-hot code in the status word
      chk(r, k == 1 ? 32'h0000_013f : k == 2 ? UPD : k == 3 ? 32'h0000_0010 : 0);
      chk(slv, k == 5);
    end
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, 12'h000, 32'h0000_0000);
      setblk(8'h00);
      def = 6'($random(seed)) | 6'h01;
      apb(1'b1, 12'h004, {16'h0000, 8'h01, 2'b00, def});
      repeat (30) @(posedge sys_clk);
      qc = {};
      ctrl.max_addr = 0;
      apb(1'b1, 12'h000, 32'h0000_0001);
      exp_cur();
      cmp(qc);
      chk(ctrl.max_addr, 8'h06);
    end
    apb(1'b1, 12'h000, 32'h0000_0000);
    setblk(8'd30);
    sp = 8'(($random(seed) & 3) + 1);
    apb(1'b1, 12'h008, 32'h0000_0bb8);
    apb(1'b1, 12'h004, {16'h0000, sp, 2'b00, def});
    repeat (30) @(posedge sys_clk);
    qo = {};
    qc = {};
    ctrl.max_addr = 0;
    apb(1'b1, 12'h000, 32'h0000_0003);
    exp_old(sp);
    cmp(qo);
    wait_end();
    chk(qc.size(), 0);
    ctrl.blk[8] = ctrl.blk[8] + 1;
    ctrl.max_addr = 0;
    exp_cur();
    cmp(qc);
    chk(ctrl.max_addr, 8'h09);
    repeat (3100) @(posedge sys_clk);
    chk(qc.size(), 0);
    apb(1'b1, 12'h008, 32'h0000_00c8);
    apb(1'b1, 12'h000, 32'h0000_0001);
    stall <= 1;
    repeat (700) @(posedge sys_clk);
    stall <= 0;
    // The warning lands at the end of the first fetch after the stall clears
    repeat (600) @(posedge sys_clk);
    chk(interp_warn, 1);
    r = 0;
    foreach (qc[j])
      r[0] = r[0] | qc[j][36];
    chk(r[0], 1);
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b1, 12'h00c, 32'h0000_0004);
    apb(1'b0, 12'h00c, 32'h0000_0000);
    chk(r[2], 0);
    setblk(8'd40);
    ctrl.blk[7][7:0] = 8'(($random(seed) & 3) + 1);
    apb(1'b1, 12'h004, {16'h0000, 8'h01, 2'b00, def});
    qo = {};
    qc = {};
    apb(1'b1, 12'h000, 32'h0000_0005);
    for (int k = 0; k < 2; k++)
    begin
      comm_flag_pin <= 1;
      exp_old(ctrl.blk[7][7:0]);
      cmp(qo);
      wait_end();
      chk(qc.size(), 0);
      comm_flag_pin <= 0;
      ctrl.max_addr = 0;
      repeat (300) @(posedge sys_clk);
      chk(ctrl.max_addr, 8'h00);
    end
    results();
  end
endmodule
bind cuf_curve_update_fetch cuf_check_props chk_i (.sys_clk, .srst, .clk_en, .psel, .penable, .pslverr,
  .fetch_req, .fetch_addr, .fetch_ack, .plot_valid, .plot_ready, .plot_curve, .plot_value, .plot_interp,
  .plot_x, .plot_step, .interp_warn);
`default_nettype wire
